// File: hdl/msu_pkg.sv
/*
  Shared constants and types of the microcore shift unit: opcode patterns,
  operand field positions, the shift-kind enumeration and reset values.
  Assumes a 16-bit instruction word and 16-bit arithmetic registers.
*/
package msu_pkg;

  localparam int unsigned WORD_W    = 16;
  localparam int unsigned WIDE_W    = 32;
  localparam int unsigned SEL_W     = 3;
  localparam int unsigned LIT_W     = 4;

  // Operand field positions
  localparam int unsigned FIRST_LSB  = 0;
  localparam int unsigned SECOND_LSB = 3;
  localparam int unsigned LIT_LSB    = 3;
  localparam int unsigned WIDE_LSB   = 3;

  // Fixed distance of the byte shifts
  localparam logic [4:0] BYTE_DIST = 5'h08;

  // Opcode patterns (upper bits of the instruction word; the wide tail matches bits 2:0)
  localparam logic [9:0]  OPC_WIDE_R_REG = 10'h0e4;
  localparam logic [8:0]  OPC_WIDE_R_LIT = 9'h070;
  localparam logic [2:0]  OPC_WIDE_TAIL  = 3'h5;
  localparam logic [9:0]  OPC_SHL_REG    = 10'h0ba;
  localparam logic [12:0] OPC_SHL_BYTE   = 13'h05df;
  localparam logic [8:0]  OPC_SHL_LIT    = 9'h05a;
  localparam logic [9:0]  OPC_SHLS_REG   = 10'h0b8;
  localparam logic [8:0]  OPC_SHLS_LIT   = 9'h058;
  localparam logic [9:0]  OPC_SHR_REG    = 10'h0b9;
  localparam logic [12:0] OPC_SHR_BYTE   = 13'h05de;
  localparam logic [8:0]  OPC_SHR_LIT    = 9'h059;
  localparam logic [9:0]  OPC_SHRS_REG   = 10'h0b7;

  // Reset values
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [31:0] RST_WIDE  = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  typedef enum logic [2:0] {
    MSU_DIR_NONE,
    MSU_DIR_LEFT,
    MSU_DIR_LEFT_SIGNED,
    MSU_DIR_RIGHT,
    MSU_DIR_RIGHT_SIGNED,
    MSU_DIR_WIDE_RIGHT
  } msu_dir_e;

endpackage

// File: hdl/msu_decode.sv
/*
  Instruction decoder of the shift unit: classifies a 16-bit word into a
  shift direction, count source and operand selects.
  Assumes the word is stable while it is decoded; purely combinational.
*/
`timescale 1ns/1ps
module msu_decode
  import msu_pkg::*;
(
  // Instruction
  input  wire logic [WORD_W-1:0] instr,
  // Classification
  output msu_dir_e               dir,
  output logic                   count_is_reg,
  output logic                   count_is_byte,
  output logic [SEL_W-1:0]       target_sel,
  output logic [SEL_W-1:0]       count_sel,
  output logic [LIT_W-1:0]       literal
);

  wire is_wide_reg = (instr[15:6] == OPC_WIDE_R_REG) && (instr[2:0] == OPC_WIDE_TAIL);
  wire is_wide_lit = (instr[15:7] == OPC_WIDE_R_LIT) && (instr[2:0] == OPC_WIDE_TAIL);
  wire is_shl_reg  = instr[15:6] == OPC_SHL_REG;
  wire is_shl_byte = instr[15:3] == OPC_SHL_BYTE;
  wire is_shl_lit  = instr[15:7] == OPC_SHL_LIT;
  wire is_shls_reg = instr[15:6] == OPC_SHLS_REG;
  wire is_shls_lit = instr[15:7] == OPC_SHLS_LIT;
  wire is_shr_reg  = instr[15:6] == OPC_SHR_REG;
  wire is_shr_byte = instr[15:3] == OPC_SHR_BYTE;
  wire is_shr_lit  = instr[15:7] == OPC_SHR_LIT;
  wire is_shrs_reg = instr[15:6] == OPC_SHRS_REG;

  assign dir = (is_wide_reg || is_wide_lit)              ? MSU_DIR_WIDE_RIGHT   :
               (is_shl_reg || is_shl_byte || is_shl_lit) ? MSU_DIR_LEFT         :
               (is_shls_reg || is_shls_lit)              ? MSU_DIR_LEFT_SIGNED  :
               (is_shr_reg || is_shr_byte || is_shr_lit) ? MSU_DIR_RIGHT        :
               is_shrs_reg                               ? MSU_DIR_RIGHT_SIGNED :
                                                           MSU_DIR_NONE;

  assign count_is_reg  = is_wide_reg || is_shl_reg || is_shls_reg || is_shr_reg || is_shrs_reg;
  assign count_is_byte = is_shl_byte || is_shr_byte;
  // Selects come only from the 3-bit arithmetic register subset
  assign target_sel    = instr[FIRST_LSB +: SEL_W];
  assign count_sel     = is_wide_reg ? instr[WIDE_LSB +: SEL_W] : instr[SECOND_LSB +: SEL_W];
  assign literal       = instr[LIT_LSB +: LIT_W];

endmodule // msu_decode

// File: hdl/msu_shift_unit.sv
/*
  Shift execution unit of a microcore: logical, arithmetic and byte shifts
  of 16-bit arithmetic registers, and right shifts of the 32-bit product
  pair, one position per core clock (byte shifts eight at once), with condition flag updates.
  Assumes a register set whose read data follow the select by one cycle,
  and a condition register that takes each flag on its write strobe.
*/
`timescale 1ns/1ps

// Behaviour
// - Product pair is high half above low half, 32 bits total.
// - Wide right-by-register shifts product pair by the selected register value.
// - Wide right-by-literal shifts product pair by the 4-bit literal.
// - Variable shifts spend one core cycle per shift position.
// - Right shifts update the shift-out and precision-loss flags.
// - Left shifts update the shift-out and overflow flags.
// - Left-by-register shifts first operand by second operand value.
// - Left-by-byte shifts first operand left by exactly eight.
// - Both byte shifts finish their shifting in one core cycle.
// - Left-by-literal shifts first operand left by the 4-bit literal.
// - Signed shifts keep the sign bit unchanged.
// - Signed-left-by-register decoded from its own ten-bit opcode.
// - Signed-left-by-literal decoded from its own nine-bit opcode.
// - Right-by-register shifts first operand by second operand value.
// - Right-by-byte shifts first operand right by exactly eight.
// - Right-by-literal shifts first operand right by the 4-bit literal.
// - Signed-right-by-register shifts arithmetically by second operand value.
// - Register operands from arithmetic register subset; literals from 4-bit field.
module msu_shift_unit
  import msu_pkg::*;
#(
  parameter int unsigned REG_SEL_W = SEL_W
)
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Instruction handshake
  input  wire logic [WORD_W-1:0]    instr,
  input  wire logic                 instr_valid,
  output logic                      instr_ready,
  output logic                      instr_unknown,
  output logic                      done,
  // Arithmetic register set, read
  output logic [REG_SEL_W-1:0]      rd_sel_target,
  output logic [REG_SEL_W-1:0]      rd_sel_count,
  input  wire logic [WORD_W-1:0]    rd_data_target,
  input  wire logic [WORD_W-1:0]    rd_data_count,
  // Arithmetic register set, write
  output logic                      wr_en,
  output logic [REG_SEL_W-1:0]      wr_sel,
  output logic [WORD_W-1:0]         wr_data,
  // Product pair
  input  wire logic [WORD_W-1:0]    product_high_half_in,
  input  wire logic [WORD_W-1:0]    product_low_half_in,
  output logic                      product_wr_en,
  output logic [WORD_W-1:0]         product_high_half,
  output logic [WORD_W-1:0]         product_low_half,
  // Condition flags
  output logic                      flags_wr_right,
  output logic                      flags_wr_left,
  output logic                      bit_out_flag,
  output logic                      precision_loss_flag,
  output logic                      overflow_flag_shift
);

  typedef enum logic [2:0] {
    MSU_ST_IDLE,
    MSU_ST_READ,
    MSU_ST_LOAD,
    MSU_ST_SHIFT,
    MSU_ST_WRITE
  } msu_state_e;

  // One shift step: returns {overflow, loss, bit out, value}
  function automatic logic [WIDE_W+2:0] msu_step(input msu_dir_e d, input logic [WIDE_W-1:0] v);
    logic [WIDE_W-1:0] nv;
    logic              out_bit;
    logic              loss;
    logic              ovf;
    nv      = v;
    out_bit = 1'b0;
    loss    = 1'b0;
    ovf     = 1'b0;
    case (d)
      MSU_DIR_LEFT:
      begin
        out_bit = v[WORD_W-1];
        ovf     = v[WORD_W-1];
        nv      = {16'h0000, v[WORD_W-2:0], 1'b0};
      end
      MSU_DIR_LEFT_SIGNED:
      begin
        // Magnitude bit leaving next to the sign differs from it: overflow
        out_bit = v[WORD_W-2];
        ovf     = v[WORD_W-2] ^ v[WORD_W-1];
        nv      = {16'h0000, v[WORD_W-1], v[WORD_W-3:0], 1'b0};
      end
      MSU_DIR_RIGHT:
      begin
        out_bit = v[0];
        loss    = v[0];
        nv      = {17'h00000, v[WORD_W-1:1]};
      end
      MSU_DIR_RIGHT_SIGNED:
      begin
        out_bit = v[0];
        loss    = v[0];
        nv      = {16'h0000, v[WORD_W-1], v[WORD_W-1:1]};
      end
      MSU_DIR_WIDE_RIGHT:
      begin
        out_bit = v[0];
        loss    = v[0];
        nv      = {1'b0, v[WIDE_W-1:1]};
      end
      default:
      begin
        nv = v;
      end
    endcase
    return {ovf, loss, out_bit, nv};
  endfunction

  msu_state_e         state;
  msu_state_e         next_state;
  msu_dir_e           dir;
  logic               count_is_reg;
  logic               count_is_byte;
  logic [SEL_W-1:0]   dec_target;
  logic [SEL_W-1:0]   dec_count;
  logic [LIT_W-1:0]   dec_literal;

  msu_dir_e           op_dir;
  logic               op_by_reg;
  logic               op_by_byte;
  logic [SEL_W-1:0]   op_target;
  logic [SEL_W-1:0]   op_count_sel;
  logic [LIT_W-1:0]   op_literal;
  logic [WIDE_W-1:0]  work;
  logic [WORD_W-1:0]  remaining;
  logic               acc_out;
  logic               acc_loss;
  logic               acc_ovf;

  msu_decode u_decode (
    .instr         (instr),
    .dir           (dir),
    .count_is_reg  (count_is_reg),
    .count_is_byte (count_is_byte),
    .target_sel    (dec_target),
    .count_sel     (dec_count),
    .literal       (dec_literal)
  );

  // Handshake and decode outcome
  wire accept       = (state == MSU_ST_IDLE) && instr_valid && (dir != MSU_DIR_NONE);
  wire op_is_wide   = op_dir == MSU_DIR_WIDE_RIGHT;
  wire op_is_right  = (op_dir == MSU_DIR_RIGHT) || (op_dir == MSU_DIR_RIGHT_SIGNED) || op_is_wide;

  assign instr_ready   = state == MSU_ST_IDLE;
  assign instr_unknown = (state == MSU_ST_IDLE) && instr_valid && (dir == MSU_DIR_NONE);
  assign rd_sel_target = REG_SEL_W'(op_target);
  assign rd_sel_count  = REG_SEL_W'(op_count_sel);

  // Count seen at load: register value, else the 4-bit literal field, which byte shifts ignore
  wire [WORD_W-1:0] load_count = op_by_reg ? rd_data_count :
                                 {12'h000, op_literal};

  // Product pair as one 32-bit operand, high half on top
  wire [WIDE_W-1:0] load_value = op_is_wide ? {product_high_half_in, product_low_half_in} :
                                              {16'h0000, rd_data_target};

  // One position per cycle for variable shifts
  wire [WIDE_W+2:0] step_res = msu_step(op_dir, work);

  // Byte shifts in a single step, eight positions at once
  wire [WORD_W-1:0] byte_val   = work[WORD_W-1:0];
  wire [WORD_W-1:0] byte_left  = {byte_val[7:0], 8'h00};
  wire [WORD_W-1:0] byte_right = {8'h00, byte_val[15:8]};
  wire              byte_out   = op_is_right ? byte_val[7] : byte_val[8];
  wire              byte_lost  = op_is_right ? (|byte_val[7:0]) : (|byte_val[15:8]);

  wire shift_last = (remaining == 16'h0001);

  always_comb
  begin
    next_state = state;
    case (state)
      MSU_ST_IDLE:
      begin
        if (accept)
        begin
          next_state = MSU_ST_READ;
        end
      end
      MSU_ST_READ:
      begin
        next_state = MSU_ST_LOAD;
      end
      MSU_ST_LOAD:
      begin
        // A zero count performs no shift step at all
        if (op_by_byte || (load_count != 16'h0000))
        begin
          next_state = MSU_ST_SHIFT;
        end
        else
        begin
          next_state = MSU_ST_WRITE;
        end
      end
      MSU_ST_SHIFT:
      begin
        if (op_by_byte || shift_last)
        begin
          next_state = MSU_ST_WRITE;
        end
      end
      MSU_ST_WRITE:
      begin
        next_state = MSU_ST_IDLE;
      end
      default:
      begin
        next_state = MSU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= MSU_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Instruction fields held for the whole execution
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      op_dir       <= MSU_DIR_NONE;
      op_by_reg    <= 1'b0;
      op_by_byte   <= 1'b0;
      op_target    <= '0;
      op_count_sel <= '0;
      op_literal   <= '0;
    end
    else if (accept)
    begin
      op_dir       <= dir;
      op_by_reg    <= count_is_reg;
      op_by_byte   <= count_is_byte;
      op_target    <= dec_target;
      op_count_sel <= dec_count;
      op_literal   <= dec_literal;
    end
  end

  // Working value, remaining count and flag accumulators
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      work      <= RST_WIDE;
      remaining <= RST_COUNT;
      acc_out   <= 1'b0;
      acc_loss  <= 1'b0;
      acc_ovf   <= 1'b0;
    end
    else if (state == MSU_ST_LOAD)
    begin
      work      <= load_value;
      remaining <= load_count;
      acc_out   <= 1'b0;
      acc_loss  <= 1'b0;
      acc_ovf   <= 1'b0;
    end
    else if ((state == MSU_ST_SHIFT) && op_by_byte)
    begin
      work     <= {16'h0000, op_is_right ? byte_right : byte_left};
      acc_out  <= byte_out;
      acc_loss <= op_is_right & byte_lost;
      acc_ovf  <= ~op_is_right & byte_lost;
    end
    else if (state == MSU_ST_SHIFT)
    begin
      work      <= step_res[WIDE_W-1:0];
      remaining <= remaining - 16'h0001;
      acc_out   <= step_res[WIDE_W];
      acc_loss  <= acc_loss | step_res[WIDE_W+1];
      acc_ovf   <= acc_ovf | step_res[WIDE_W+2];
    end
  end

  // Value and flags that the shift state produces in its final cycle
  wire [WIDE_W-1:0] fin_wide   = op_by_byte ? {16'h0000, op_is_right ? byte_right : byte_left} :
                                              step_res[WIDE_W-1:0];
  wire              fin_out    = op_by_byte ? byte_out : step_res[WIDE_W];
  wire              fin_loss   = op_is_right & (op_by_byte ? byte_lost : (acc_loss | step_res[WIDE_W+1]));
  wire              fin_ovf    = ~op_is_right & (op_by_byte ? byte_lost : (acc_ovf | step_res[WIDE_W+2]));
  // Zero count skips the shift state; work is not loaded yet, so use the load value
  wire              from_shift = state == MSU_ST_SHIFT;
  wire [WIDE_W-1:0] res_wide   = from_shift ? fin_wide : load_value;

  // Results and flags, written in the completion cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_sel              <= '0;
      wr_data             <= RST_WORD;
      product_high_half   <= RST_WORD;
      product_low_half    <= RST_WORD;
      bit_out_flag        <= 1'b0;
      precision_loss_flag <= 1'b0;
      overflow_flag_shift <= 1'b0;
    end
    else if (next_state == MSU_ST_WRITE)
    begin
      wr_sel              <= REG_SEL_W'(op_target);
      wr_data             <= res_wide[WORD_W-1:0];
      product_high_half   <= res_wide[WIDE_W-1:WORD_W];
      product_low_half    <= res_wide[WORD_W-1:0];
      bit_out_flag        <= from_shift & fin_out;
      precision_loss_flag <= from_shift & fin_loss;
      overflow_flag_shift <= from_shift & fin_ovf;
    end
  end

  // Write strobes in the single completion cycle
  wire in_write = state == MSU_ST_WRITE;

  assign done           = in_write;
  assign wr_en          = in_write && !op_is_wide;
  assign product_wr_en  = in_write && op_is_wide;
  assign flags_wr_right = in_write && op_is_right;
  assign flags_wr_left  = in_write && !op_is_right;

endmodule // msu_shift_unit

// File: tb/msu_far_model.sv
/*
  Far-side model: arithmetic register set with read data one cycle after
  the selects, and the product pair register.
  Assumes the bench preloads regs and prod between instructions.
*/
`timescale 1ns/1ps
module msu_far_model
  import msu_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register set
  input  wire logic [SEL_W-1:0]  rd_sel_target,
  input  wire logic [SEL_W-1:0]  rd_sel_count,
  output logic      [WORD_W-1:0] rd_data_target,
  output logic      [WORD_W-1:0] rd_data_count,
  input  wire logic              wr_en,
  input  wire logic [SEL_W-1:0]  wr_sel,
  input  wire logic [WORD_W-1:0] wr_data,
  // Product pair
  input  wire logic              product_wr_en,
  input  wire logic [WORD_W-1:0] product_high_half,
  input  wire logic [WORD_W-1:0] product_low_half,
  output logic      [WORD_W-1:0] product_high_half_in,
  output logic      [WORD_W-1:0] product_low_half_in
);
  logic [WORD_W-1:0] regs [8];
  logic [WIDE_W-1:0] prod;

  // Plain always: the bench also writes regs and prod
  always @(posedge clk)
  begin
    rd_data_target <= regs[rd_sel_target];
    rd_data_count  <= regs[rd_sel_count];
    if (wr_en)
      regs[wr_sel] <= wr_data;
    if (product_wr_en)
      prod <= {product_high_half, product_low_half};
  end

  assign product_high_half_in = prod[31:16];
  assign product_low_half_in  = prod[15:0];
endmodule // msu_far_model

// File: tb/msu_shift_unit_asserts.sv
/*
  Port-level checks of the shift unit, with a tracker that follows each
  taken instruction to completion.
  Assumes one instruction in flight and counts below 250.
*/
`timescale 1ns/1ps
module msu_shift_unit_chk
  import msu_pkg::*;
#(
  parameter int unsigned REG_SEL_W = SEL_W
)
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Handshake
  input wire logic [WORD_W-1:0]    instr,
  input wire logic                 instr_valid,
  input wire logic                 instr_ready,
  input wire logic                 instr_unknown,
  input wire logic                 done,
  // Register set and strobes
  input wire logic [WORD_W-1:0]    rd_data_target,
  input wire logic [WORD_W-1:0]    rd_data_count,
  input wire logic                 wr_en,
  input wire logic [WORD_W-1:0]    wr_data,
  input wire logic                 product_wr_en,
  input wire logic                 flags_wr_right,
  input wire logic                 flags_wr_left
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire       take   = instr_valid && instr_ready && !instr_unknown;
  wire [9:0] op10   = instr[15:6];
  wire [8:0] op9    = instr[15:7];
  wire       d_bl   = instr[15:3] == OPC_SHL_BYTE;
  wire       d_br   = instr[15:3] == OPC_SHR_BYTE;
  wire       d_wide = op10 == OPC_WIDE_R_REG || op9 == OPC_WIDE_R_LIT;
  wire       d_reg  = op10 inside {OPC_WIDE_R_REG, OPC_SHL_REG, OPC_SHLS_REG, OPC_SHR_REG, OPC_SHRS_REG};
  wire       d_sign = op10 inside {OPC_SHLS_REG, OPC_SHRS_REG} || op9 == OPC_SHLS_LIT;
  wire       d_left = d_bl || op10 inside {OPC_SHL_REG, OPC_SHLS_REG} || op9 inside {OPC_SHL_LIT, OPC_SHLS_LIT};
  wire [7:0] lit_lat = (d_bl || d_br) ? 8'h04 : 8'h03 + 8'(instr[6:3]);

  logic [7:0]        cnt;
  logic [7:0]        lat;
  logic [WORD_W-1:0] orig;
  logic              k_bl, k_br, k_wide, k_reg, k_sign, k_left;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt <= 8'h00;
    else if (take)
      cnt <= 8'h01;
    else if (done)
      cnt <= 8'h00;
    else if (cnt != 8'h00)
      cnt <= cnt + 8'h01;

  // Register counts become known only in the load cycle
  always_ff @(posedge clk)
    if (take)
    begin
      {k_bl, k_br, k_wide, k_reg, k_sign, k_left} <= {d_bl, d_br, d_wide, d_reg, d_sign, d_left};
      lat <= lit_lat;
    end
    else if (cnt == 8'h02)
    begin
      orig <= rd_data_target;
      if (k_reg)
        lat <= 8'h03 + rd_data_count[7:0];
    end

  a_ready_after_done: assert property (done |=> instr_ready)
    else $error("ready not back after done");
  a_busy_after_take: assert property (take |=> !instr_ready [*3])
    else $error("ready during execution");
  a_done_on_count: assert property (done |-> cnt == lat)
    else $error("done at wrong cycle");
  a_no_late_done: assert property (cnt != 8'h00 |-> cnt <= lat)
    else $error("done missing");
  a_wide_strobe: assert property (done |-> product_wr_en == k_wide && wr_en == !k_wide)
    else $error("wrong result strobe");
  a_flag_side: assert property (done |-> flags_wr_left == k_left && flags_wr_right == !k_left)
    else $error("wrong flag strobe");
  a_unknown_refused: assert property (instr_unknown |=> instr_ready && cnt == 8'h00)
    else $error("unknown word taken");
  a_sign_kept: assert property (done && k_sign && !k_wide |-> wr_data[15] == orig[15])
    else $error("sign bit changed");
  a_byte_left: assert property (done && k_bl |-> wr_data == {orig[7:0], 8'h00})
    else $error("left byte result");
  a_byte_right: assert property (done && k_br |-> wr_data == {8'h00, orig[15:8]})
    else $error("right byte result");

  c_byte_done: cover property (done && k_br);
  c_wide_done: cover property (done && k_wide);
  c_unknown: cover property (instr_unknown);
endmodule // msu_shift_unit_chk

bind msu_shift_unit msu_shift_unit_chk #(.REG_SEL_W(REG_SEL_W)) chk (.*);

// File: tb/tb_top.sv
/*
  Self-checking bench: every shift opcode with random operands and
  boundary counts, a back-to-back pair and an unknown word.
  Assumes the far-side model holds the register set and product pair.
*/
`timescale 1ns/1ps
module tb_top
  import msu_pkg::*;
;
  logic              clk, rst, instr_valid, instr_ready, instr_unknown, done;
  logic [WORD_W-1:0] instr, rd_data_target, rd_data_count, wr_data;
  logic [SEL_W-1:0]  rd_sel_target, rd_sel_count, wr_sel;
  logic              wr_en, product_wr_en, flags_wr_right, flags_wr_left;
  logic              bit_out_flag, precision_loss_flag, overflow_flag_shift;
  logic [WORD_W-1:0] product_high_half_in, product_low_half_in, product_high_half, product_low_half;
  logic [45:0]       notes[$];
  logic [45:0]       got;
  int                n_errors = 0, n_compared = 0, cyc = 0, acc_cyc = 0;

  msu_shift_unit uut (.*);
  msu_far_model  pm (.*);

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check_note(input logic [45:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic check_bit(input logic e, g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] encode(int op, logic [2:0] t, c, logic [3:0] l);
    case (op)
      0: return {OPC_SHL_REG, c, t};
      1: return {OPC_SHLS_REG, c, t};
      2: return {OPC_SHR_REG, c, t};
      3: return {OPC_SHRS_REG, c, t};
      4: return {OPC_SHL_LIT, l, t};
      5: return {OPC_SHLS_LIT, l, t};
      6: return {OPC_SHR_LIT, l, t};
      7: return {OPC_SHL_BYTE, t};
      8: return {OPC_SHR_BYTE, t};
      9: return {OPC_WIDE_R_REG, c, OPC_WIDE_TAIL};
      default: return {OPC_WIDE_R_LIT, l, OPC_WIDE_TAIL};
    endcase
  endfunction

  // Note: latency, strobes, shift-out, loss or overflow, result
  function automatic logic [45:0] ref_op(int op, logic [31:0] v, int n);
    logic sb, f2, lf, sg, wd;
    int   k;
    lf = op inside {0, 1, 4, 5, 7};
    sg = op inside {1, 3, 5};
    wd = op >= 9;
    sb = 1'b0;
    f2 = 1'b0;
    if (op inside {7, 8})
      n = 8;
    for (k = 0; k < n; k++)
    begin
      sb = lf ? v[sg ? 14 : 15] : v[0];
      f2 |= (lf && sg) ? v[14] ^ v[15] : sb;
      if (wd)
        v = v >> 1;
      else
        v = lf ? {16'h0, sg ? v[15] : v[14], v[13:0], 1'b0} : {16'h0, sg & v[15], v[15:1]};
    end
    return {(op inside {7, 8}) ? 8'h04 : 8'(3 + n), !wd, wd, !lf, lf, sb, f2, v};
  endfunction

  task automatic setup(input logic [2:0] t, c, input logic [15:0] tv, cv, input logic [31:0] pv);
    int k;
    @(negedge clk);
    for (k = 0; k < 200 && instr_ready !== 1'b1; k++)
      @(negedge clk);
    if (instr_ready !== 1'b1)
      n_errors++;
    @(posedge clk);
    pm.regs[t] <= tv;
    pm.regs[c] <= cv;
    pm.prod    <= pv;
  endtask

  // Hold keeps valid up so the next word follows with no gap
  task automatic issue(input logic [15:0] w, input logic [45:0] e, input bit hold);
    int k;
    instr       <= w;
    instr_valid <= 1'b1;
    notes.push_back(e);
    for (k = 0; k < 200; k++)
    begin
      @(negedge clk);
      if (instr_ready === 1'b1)
        break;
    end
    if (instr_ready !== 1'b1)
      n_errors++;
    @(posedge clk);
    acc_cyc = cyc;
    if (!hold)
      instr_valid <= 1'b0;
  endtask

  always @(posedge clk)
    if (rst === 1'b0 && done === 1'b1)
    begin
      got = {8'(cyc - acc_cyc), wr_en, product_wr_en, flags_wr_right, flags_wr_left, bit_out_flag,
             flags_wr_left ? overflow_flag_shift : precision_loss_flag,
             product_wr_en ? {product_high_half, product_low_half} : {13'h0, wr_sel, wr_data}};
      check_note((notes.size() > 0) ? notes.pop_front() : 46'h0, got);
    end

  initial
  begin
    #(400_000);
    n_errors++;
    close_out();
  end

  initial
  begin
    int          op, i, n;
    logic [2:0]  t, c;
    logic [15:0] tv;
    logic [31:0] pv;
    logic [45:0] e;
    clk = 1'b0;
    rst = 1'b1;
    instr = 16'h0000;
    instr_valid = 1'b0;
    void'($urandom(40165));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (op = 0; op < 11; op++)
      for (i = 0; i < 8; i++)
      begin
        t  = 3'($urandom);
        c  = t ^ (3'($urandom % 7) + 3'h1);
        tv = 16'($urandom);
        pv = $urandom;
        n  = (i == 0) ? 0 : (i == 1) ? 15 : (i == 2 && op inside {0, 1, 2, 3, 9}) ? 17 : 1 + $urandom % 15;
        setup(t, c, tv, 16'(n), pv);
        e = ref_op(op, (op >= 9) ? pv : {16'h0, tv}, n);
        if (op < 9)
          e[18:16] = t;
        issue(encode(op, t, c, 4'(n)), e, 1'b0);
      end
    setup(3'h2, 3'h5, 16'hc3a5, 16'h0000, 32'h0);
    e = ref_op(7, 32'h0000_c3a5, 0);
    e[18:16] = 3'h2;
    issue(encode(7, 3'h2, 3'h0, 4'h0), e, 1'b1);
    e = ref_op(8, {16'h0, e[15:0]}, 0);
    e[18:16] = 3'h2;
    issue(encode(8, 3'h2, 3'h0, 4'h0), e, 1'b0);
    setup(3'h0, 3'h1, 16'h0000, 16'h0000, 32'h0);
    instr       <= 16'hffff;
    instr_valid <= 1'b1;
    @(negedge clk);
    check_bit(1'b1, instr_unknown);
    check_bit(1'b1, instr_ready);
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (6) @(posedge clk);
    check_bit(1'b1, notes.size() == 0);
    close_out();
  end
endmodule // tb_top
